// ==== shared/wdog_pkg.sv ====
// constants, types and register map for the windowed watchdog
package wdog_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned LS_HZ = 32_768;
  localparam int unsigned LS_DIV = CLK_HZ / LS_HZ;
  localparam int CNT_W = 18;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CLEAR = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] CLR_KEY = 8'h5a;
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_WIN_EN = 3;
  localparam int CTRL_WIN_75 = 4;
  localparam int CTRL_HALT_RUN = 5;
  localparam int ST_NMI = 0;
  localparam int ST_RST_OVF = 1;
  localparam int ST_RST_INV = 2;
  localparam int ST_ENABLED = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // overflow periods in low-speed ticks: 7.8,15.6,31.3,62.5,125,500,2000,8000 ms
  localparam logic [CNT_W-1:0] PERIOD_TICKS [8] = '{
    18'h00100, 18'h00200, 18'h00400, 18'h00800,
    18'h01000, 18'h04000, 18'h10000, 18'h3ffff};
  typedef struct packed {
    logic halt_run;
    logic win_75;
    logic win_en;
    logic [2:0] sel;
  } ctrl_s;
  localparam ctrl_s CTRL_RST = '{halt_run: 1'b0, win_75: 1'b0,
                                 win_en: 1'b0, sel: 3'h7};
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_WARNED = 2'b10
  } stage_e;
endpackage

// ==== core/wdog_tick.sv ====
// divider making the low-speed count enable pulse
`timescale 1ns/1ns
module wdog_tick #(
  parameter int unsigned DIV = wdog_pkg::LS_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  output logic tick
);
  logic [11:0] div_ff;
  logic [11:0] nxt_div;
  logic hit;

  assign hit = (div_ff == 12'(DIV - 1));
  assign tick = hit;

  always_comb begin
    nxt_div = hit ? 12'h000 : div_ff + 12'h001;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= 12'h000;
    end else begin
      div_ff <= nxt_div;
    end
  end
endmodule

// ==== core/windowed_watchdog_timer.sv ====
// windowed watchdog with axi4-lite register access
`timescale 1ns/1ns
module windowed_watchdog_timer #(
  parameter int unsigned TICK_DIV = wdog_pkg::LS_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic code_opt_en,
  input wire logic halt_mode,
  output logic nmi_req,
  output logic sys_reset_req
);
  logic tick;
  // synchronisers for pin inputs
  logic opt_s1_ff, opt_s2_ff, halt_s1_ff, halt_s2_ff;
  // option latch
  logic loaded_ff, nxt_loaded, enabled_ff, nxt_enabled;
  // registers and counter
  wdog_pkg::ctrl_s ctrl_ff, nxt_ctrl;
  logic [wdog_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  wdog_pkg::stage_e stage_ff, nxt_stage;
  logic [2:0] status_ff, nxt_status;
  logic rst_ff, nxt_rst;
  // bus state
  logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
  logic [7:0] waddr_ff, nxt_waddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  // helpers
  logic [wdog_pkg::CNT_W-1:0] period, win_start;
  logic do_write, clear_wr, counting, overflow, in_window;

  wdog_tick #(.DIV(TICK_DIV)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick)
  );

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  // no mask stage: level straight from the stage register
  assign nmi_req = (stage_ff == wdog_pkg::ST_WARNED);
  assign sys_reset_req = rst_ff;

  assign period = wdog_pkg::PERIOD_TICKS[ctrl_ff.sel];
  // permitted part sits at the end of the period
  assign win_start = ctrl_ff.win_75 ? (period >> 2) : (period >> 1);
  assign in_window = !ctrl_ff.win_en || (cnt_ff >= win_start);
  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
  assign clear_wr = do_write && (waddr_ff == wdog_pkg::OFS_CLEAR) &&
                    wstrb_ff[0] && (wdata_ff[7:0] == wdog_pkg::CLR_KEY);
  assign counting = enabled_ff && tick &&
                    (!halt_s2_ff || ctrl_ff.halt_run);
  assign overflow = counting && (cnt_ff == period - 1'b1);

  always_comb begin
    nxt_loaded = 1'b1;
    // option is a start-up strap, later changes ignored
    nxt_enabled = loaded_ff ? enabled_ff : opt_s2_ff;
    nxt_ctrl = ctrl_ff;
    nxt_cnt = cnt_ff;
    nxt_stage = stage_ff;
    nxt_status = status_ff;
    nxt_rst = 1'b0;
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;

    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_got = 1'b1;
      nxt_waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = wdog_pkg::RESP_OKAY;
      case ({waddr_ff[7:2], 2'b00})
        wdog_pkg::OFS_CTRL: begin
          if (wstrb_ff[0]) begin
            nxt_ctrl = wdog_pkg::ctrl_s'(wdata_ff[5:0]);
          end
        end
        wdog_pkg::OFS_CLEAR: begin
        end
        wdog_pkg::OFS_STATUS: begin
          if (wstrb_ff[0]) begin
            nxt_status = status_ff & ~wdata_ff[2:0];
          end
        end
        default: begin
          nxt_bresp = wdog_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end

    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = wdog_pkg::RESP_OKAY;
      nxt_rdata = 32'h0000_0000;
      case ({s_axi_araddr[7:2], 2'b00})
        wdog_pkg::OFS_CTRL: nxt_rdata[5:0] = 6'(ctrl_ff);
        wdog_pkg::OFS_CLEAR: nxt_rdata = 32'h0000_0000;
        wdog_pkg::OFS_COUNT: nxt_rdata[wdog_pkg::CNT_W-1:0] = cnt_ff;
        wdog_pkg::OFS_STATUS: begin
          nxt_rdata[2:0] = status_ff;
          nxt_rdata[wdog_pkg::ST_NMI] = nmi_req;
          nxt_rdata[wdog_pkg::ST_ENABLED] = enabled_ff;
        end
        default: nxt_rresp = wdog_pkg::RESP_SLVERR;
      endcase
    end
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end

    if (counting) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
    if (clear_wr && enabled_ff) begin
      if (in_window) begin
        nxt_cnt = '0;
        nxt_stage = wdog_pkg::ST_RUN;
      end else begin
        nxt_cnt = '0;
        nxt_stage = wdog_pkg::ST_RUN;
        nxt_rst = 1'b1;
        nxt_status[wdog_pkg::ST_RST_INV] = 1'b1;
      end
    end else if (overflow) begin
      nxt_cnt = '0;
      case (stage_ff)
        wdog_pkg::ST_RUN: begin
          if (ctrl_ff.win_en) begin
            nxt_rst = 1'b1;
            nxt_status[wdog_pkg::ST_RST_OVF] = 1'b1;
          end else begin
            nxt_stage = wdog_pkg::ST_WARNED;
          end
        end
        wdog_pkg::ST_WARNED: begin
          nxt_stage = wdog_pkg::ST_RUN;
          nxt_rst = 1'b1;
          nxt_status[wdog_pkg::ST_RST_OVF] = 1'b1;
        end
        default: nxt_stage = wdog_pkg::ST_RUN;
      endcase
    end
    // bit 0 of status mirrors the nmi level, no stored copy
    nxt_status[wdog_pkg::ST_NMI] = 1'b0;
  end

  always_ff @(posedge aclk) begin
    opt_s1_ff <= code_opt_en;
    opt_s2_ff <= opt_s1_ff;
    halt_s1_ff <= halt_mode;
    halt_s2_ff <= halt_s1_ff;
    if (!aresetn) begin
      loaded_ff <= 1'b0;
      enabled_ff <= 1'b0;
      ctrl_ff <= wdog_pkg::CTRL_RST;
      cnt_ff <= '0;
      stage_ff <= wdog_pkg::ST_RUN;
      status_ff <= 3'h0;
      rst_ff <= 1'b0;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      waddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
    end else begin
      // strap sampled once sync chain has settled
      loaded_ff <= nxt_loaded;
      enabled_ff <= nxt_enabled;
      ctrl_ff <= nxt_ctrl;
      cnt_ff <= nxt_cnt;
      stage_ff <= nxt_stage;
      status_ff <= nxt_status;
      rst_ff <= nxt_rst;
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end
endmodule

// ==== verif/wdog_properties.sv ====
// checker: bus handshake and reset request properties
`timescale 1ns/1ns
module wdog_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic nmi_req,
  input wire logic sys_reset_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rst_pulse_a: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset request wider than one cycle");
  rst_no_nmi_a: assert property (sys_reset_req |-> !nmi_req)
    else $error("nmi high with reset request");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while read pending");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready while response pending");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid)
    else $error("read answer late");
  b_late_a: assert property ($rose(s_axi_bvalid) |->
    !$past(s_axi_awready))
    else $error("write response without capture");
endmodule
bind windowed_watchdog_timer wdog_properties u_props (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata),
  .nmi_req(nmi_req),
  .sys_reset_req(sys_reset_req)
);

// ==== verif/windowed_watchdog_timer_tb_top.sv ====
// testbench for the windowed watchdog
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module windowed_watchdog_timer_tb_top;
  logic aclk = 1'h0, aresetn = 1'h0, code_opt_en = 1'h1, halt_mode = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, wr_resp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, nmi_req, sys_reset_req, sn, wr_rst;
  logic [31:0] seed = 32'h4, d, c;
  int n_errors = 0, samples_checked = 0, n;
  windowed_watchdog_timer #(.TICK_DIV(4)) DUT (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .code_opt_en(code_opt_en),
    .halt_mode(halt_mode),
    .nmi_req(nmi_req),
    .sys_reset_req(sys_reset_req)
  );
  initial begin
    forever #4 aclk = ~aclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic final_report();
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // sampling at the falling edge avoids racing the design's own flops
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, t;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(negedge aclk);
      t = !ta && s_axi_awready;
      ta |= s_axi_awready;
      tw |= s_axi_wready;
      @(posedge aclk);
      if (t) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end while (!(ta && tw));
    s_axi_bready <= 1'h1;
    // reset pulse launches with bvalid, so it is caught here
    do begin
      @(negedge aclk);
      t = s_axi_bvalid;
      wr_resp = s_axi_bresp;
      wr_rst = sys_reset_req;
      @(posedge aclk);
    end while (!t);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dv,
                    output logic [1:0] rv);
    logic t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end while (!t);
    s_axi_arvalid <= 1'h0;
    // ready raised late so the data must stand a cycle
    @(posedge aclk);
    s_axi_rready <= 1'h1;
    do begin
      @(negedge aclk);
      t = s_axi_rvalid;
      dv = s_axi_rdata;
      rv = s_axi_rresp;
      @(posedge aclk);
    end while (!t);
    s_axi_rready <= 1'h0;
  endtask
  task automatic wt(input logic rs, input int lim);
    n = 0;
    sn = 1'h0;
    do begin
      @(negedge aclk);
      n++;
      sn |= nmi_req;
    end while (!(rs ? sys_reset_req : nmi_req) && n < lim);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    rd(wdog_pkg::OFS_CTRL, d, r);
    `CHK("ctrl rst", 32'h7, d)
    rd(wdog_pkg::OFS_STATUS, d, r);
    `CHK("enabled", 32'h8, d)
    `CHK("rd okay", wdog_pkg::RESP_OKAY, r)
    rd(8'h40, d, r);
    `CHK("unmapped", wdog_pkg::RESP_SLVERR, r)
    wr(8'h40, 32'h0);
    `CHK("wr unmapped", wdog_pkg::RESP_SLVERR, wr_resp)
    for (int i = 0; i < 6; i++) begin
      c = xs();
      wr(wdog_pkg::OFS_CTRL, c);
      `CHK("wr okay", wdog_pkg::RESP_OKAY, wr_resp)
      rd(wdog_pkg::OFS_CTRL, d, r);
      `CHK("ctrl rw", {26'h0, c[5:0]}, d)
    end
    wr(wdog_pkg::OFS_CTRL, 32'h0);
    wr(wdog_pkg::OFS_CLEAR, 32'h5a);
    `CHK("clear ok", 1'h0, wr_rst)
    rd(wdog_pkg::OFS_COUNT, d, r);
    `CHK("count low", 1'h1, d < 32'h4)
    wt(1'h0, 1100);
    `CHK("nmi time", 1'h1, n > 990 && n < 1030)
    rd(wdog_pkg::OFS_STATUS, d, r);
    `CHK("nmi stat", 32'h9, d)
    wt(1'h1, 1100);
    `CHK("ovf time", 1'h1, n > 990 && n < 1030)
    rd(wdog_pkg::OFS_STATUS, d, r);
    `CHK("ovf stat", 32'ha, d)
    wr(wdog_pkg::OFS_STATUS, 32'h6);
    wr(wdog_pkg::OFS_CLEAR, 32'h5a);
    halt_mode <= 1'h1;
    repeat (4) @(posedge aclk);
    rd(wdog_pkg::OFS_COUNT, c, r);
    repeat (40) @(posedge aclk);
    rd(wdog_pkg::OFS_COUNT, d, r);
    `CHK("frozen", c, d)
    wr(wdog_pkg::OFS_CTRL, 32'h20);
    rd(wdog_pkg::OFS_COUNT, c, r);
    repeat (40) @(posedge aclk);
    rd(wdog_pkg::OFS_COUNT, d, r);
    `CHK("halt run", 1'h1, d > c)
    halt_mode <= 1'h0;
    wr(wdog_pkg::OFS_CTRL, 32'h8);
    wr(wdog_pkg::OFS_CLEAR, 32'h5a);
    `CHK("bad clear", 1'h1, wr_rst)
    rd(wdog_pkg::OFS_STATUS, d, r);
    `CHK("bad stat", 32'hc, d)
    wr(wdog_pkg::OFS_STATUS, 32'h4);
    repeat (700) @(posedge aclk);
    wr(wdog_pkg::OFS_CLEAR, 32'h5a);
    `CHK("win50 clr", 1'h0, wr_rst)
    wt(1'h1, 1100);
    `CHK("win50", 1'h1, n > 990 && n < 1030)
    `CHK("no nmi", 1'h0, sn)
    wr(wdog_pkg::OFS_CTRL, 32'h18);
    repeat (300) @(posedge aclk);
    wr(wdog_pkg::OFS_CLEAR, 32'h5a);
    `CHK("win75 clr", 1'h0, wr_rst)
    wt(1'h1, 1100);
    `CHK("win75", 1'h1, n > 990 && n < 1030)
    // strap dropped late must not stop a running unit
    code_opt_en <= 1'h0;
    repeat (8) @(posedge aclk);
    rd(wdog_pkg::OFS_STATUS, d, r);
    `CHK("strap late", 32'ha, d)
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(wdog_pkg::OFS_STATUS, d, r);
    `CHK("strap off", 32'h0, d)
    rd(wdog_pkg::OFS_CTRL, d, r);
    `CHK("ctrl rst2", 32'h7, d)
    repeat (40) @(posedge aclk);
    rd(wdog_pkg::OFS_COUNT, d, r);
    `CHK("off count", 32'h0, d)
    final_report();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    final_report();
  end
endmodule
